// ==== src/host_port_params.svh ====
// Constants for the strobe-driven parallel host port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define HP_ADDR_W        7
`define HP_DATA_W        8
`define HP_NUM_REGS      128
`define HP_REG_RESET     8'h00
`define HP_ACK_DELAY     2
`define HP_CNT_W         2
`endif

// ==== src/host_port_pkg.sv ====
// Types shared by both ends of the host port
`include "host_port_params.svh"
package host_port_pkg;
    typedef logic [`HP_ADDR_W-1:0] addr_t;
    typedef logic [`HP_DATA_W-1:0] data_t;
    typedef enum logic {BUS_SPLIT, BUS_COMBINED} bus_style_t;
    typedef enum logic [1:0] {H_IDLE, H_ADDR, H_STROBE, H_END} host_state_t;
endpackage

// ==== src/host_port_if.sv ====
// Pin-level carrier between the microprocessor and the device port
`timescale 1ns/1ps
interface host_port_if;
    import host_port_pkg::*;
    logic                  host_mode;
    bus_style_t            bus_style;
    logic                  read_or_data_strobe_n;
    logic                  addr_latch_or_strobe;
    logic                  chip_select_n;
    logic                  write_or_rw_id;
    addr_t                 addr;
    data_t                 data_host_out;
    logic                  data_host_oe;
    data_t                 data_dev_out;
    logic                  data_dev_oe;
    logic                  cycle_done_ack_n;
    modport device (
        input  host_mode, bus_style, read_or_data_strobe_n, addr_latch_or_strobe, chip_select_n,
        input  write_or_rw_id, addr, data_host_out, data_host_oe,
        output data_dev_out, data_dev_oe, cycle_done_ack_n
    );
    modport host (
        output host_mode, bus_style, read_or_data_strobe_n, addr_latch_or_strobe, chip_select_n,
        output write_or_rw_id, addr, data_host_out, data_host_oe,
        input  data_dev_out, data_dev_oe, cycle_done_ack_n
    );
endinterface

// ==== src/host_port_device.sv ====
// Device end: strobe decode, register file and hardware-mode commands
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Combined style: read pin is data strobe
// RULE2 - Hardware mode: pins command all-ones, ch1-3
// RULE3 - Split style: high latch pulse starts cycle
// RULE4 - Split style: address latched on latch fall
// RULE5 - Split style: address buffers open while latch high
// RULE6 - Combined style: address buffers open while strobe low
// RULE7 - Host lowers strobe with or after address
// RULE8 - Host holds strobe low through cycle
// RULE9 - Strobe and select tied together work
// RULE10 - Cycles answered only under chip select
// RULE11 - Deselected: pins ignored, data tri-stated
// RULE12 - Split style: write on write strobe rise
// RULE13 - Combined style: direction sampled at strobe fall
// RULE14 - Drive data during read strobe only
// RULE15 - Ack low only when cycle can finish
module host_port_device (
    host_port_if.device             bus,
    input  wire logic               clk,
    input  wire logic               rst_n,
    output logic [3:1]              send_all_ones,
    output host_port_pkg::addr_t    last_addr,
    output host_port_pkg::data_t    last_wdata,
    output logic                    write_pulse
);
    import host_port_pkg::*;

    // Register file, pin history and cycle state
    data_t                 regs [`HP_NUM_REGS];
    addr_t                 addr_reg;
    addr_t                 addr_next;
    logic                  latch_prev_reg;
    logic                  wr_prev_reg;
    logic                  ds_prev_reg;
    logic                  rw_read_reg;
    logic                  rw_read_next;
    logic                  in_cycle_reg;
    logic                  in_cycle_next;
    logic [`HP_CNT_W-1:0]  cnt_reg;
    logic [`HP_CNT_W-1:0]  cnt_next;
    data_t                 rdata_reg;
    data_t                 rdata_next;
    data_t                 wdata_reg;
    data_t                 wdata_next;
    logic                  wpulse_reg;

    // Wait count has reached the point where the cycle may finish
    function automatic logic count_done(input logic [`HP_CNT_W-1:0] count);
        return count == `HP_CNT_W'(`HP_ACK_DELAY);
    endfunction

    // Host mode with the given bus style
    function automatic logic style_is(input logic mode, input bus_style_t style, input bus_style_t want);
        return mode && style == want;
    endfunction

    // Decode of mode and strobes
    wire   split       = style_is(bus.host_mode, bus.bus_style, BUS_SPLIT);
    wire   combined    = style_is(bus.host_mode, bus.bus_style, BUS_COMBINED);
    // RULE10 chip select gate
    wire   selected    = bus.host_mode && !bus.chip_select_n;
    // RULE5 split address open
    wire   addr_open_s = split && bus.addr_latch_or_strobe;
    // RULE6 combined address open
    wire   addr_open_c = combined && !bus.addr_latch_or_strobe;
    // RULE9 tied strobe and select
    wire   addr_open   = (addr_open_s || addr_open_c) && selected;
    // RULE4 split latch falling edge
    wire   latch_fall  = split && selected && latch_prev_reg && !bus.addr_latch_or_strobe;
    // RULE1 data strobe asserted
    wire   ds_active   = combined && selected && !bus.read_or_data_strobe_n;
    wire   ds_fall     = ds_active && ds_prev_reg;
    wire   rd_active_s = split && selected && !bus.read_or_data_strobe_n;
    wire   wr_active_s = split && selected && !bus.write_or_rw_id;
    // RULE12 write strobe rising edge
    // Select must still be low when the write strobe rises
    wire   wr_rise_s   = split && selected && !wr_prev_reg && bus.write_or_rw_id;
    wire   cur_read    = split ? rd_active_s : (ds_active && rw_read_reg);
    // Combined write lands once the data strobe negates
    wire   cur_write_c = combined && in_cycle_reg && !rw_read_reg && !ds_active;
    wire   strobe_on   = rd_active_s || wr_active_s || ds_active;
    wire   capture     = latch_fall || addr_open;
    wire   addr_t cur_addr = (addr_open_c && selected) ? bus.addr : addr_reg;
    wire   do_write    = wr_rise_s || cur_write_c;
    wire   answer_now  = in_cycle_reg && count_done(cnt_reg);

    // RULE3 capture address while open and on latch fall
    assign addr_next     = capture ? bus.addr : addr_reg;
    // RULE13 direction at strobe fall
    assign rw_read_next  = ds_fall ? bus.write_or_rw_id : rw_read_reg;
    // RULE11 deselect or idle strobe ends the cycle
    assign in_cycle_next = strobe_on && selected;
    // Count holds at the answer point until the strobe negates
    assign cnt_next      = !in_cycle_next ? `HP_CNT_W'(0)
                         : count_done(cnt_reg) ? cnt_reg
                         : cnt_reg + `HP_CNT_W'(1);
    // Read data staged every cycle so it stands at the answer
    assign rdata_next    = regs[cur_addr];
    assign wdata_next    = do_write ? bus.data_host_out : wdata_reg;

    // RULE2 all-ones commands, ch1 strobe, ch2 latch, ch3 select
    assign send_all_ones = bus.host_mode ? 3'b000
                         : {bus.chip_select_n, bus.addr_latch_or_strobe, bus.read_or_data_strobe_n};
    // RULE14 drive only during read
    assign bus.data_dev_oe      = cur_read && answer_now;
    assign bus.data_dev_out     = rdata_reg;
    // RULE15 ack once data or write ready
    assign bus.cycle_done_ack_n = !(strobe_on && answer_now);
    assign last_addr            = addr_reg;
    assign last_wdata           = wdata_reg;
    assign write_pulse          = wpulse_reg;

    // Latch pin history, idle low in split style
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_prev_reg <= 1'b0;
        end else begin
            latch_prev_reg <= bus.addr_latch_or_strobe;
        end
    end

    // Write strobe history, idle high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_reg <= 1'b1;
        end else begin
            wr_prev_reg <= bus.write_or_rw_id;
        end
    end

    // Data strobe history, idle high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_prev_reg <= 1'b1;
        end else begin
            ds_prev_reg <= bus.read_or_data_strobe_n;
        end
    end

    // Address latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= '0;
        end else begin
            addr_reg <= addr_next;
        end
    end

    // Transfer direction of the combined style
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rw_read_reg <= 1'b1;
        end else begin
            rw_read_reg <= rw_read_next;
        end
    end

    // Cycle in progress
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_cycle_reg <= 1'b0;
        end else begin
            in_cycle_reg <= in_cycle_next;
        end
    end

    // Wait count toward the answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Read data holding register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `HP_REG_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Last written byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdata_reg <= `HP_REG_RESET;
        end else begin
            wdata_reg <= wdata_next;
        end
    end

    // One-cycle pulse after each committed write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wpulse_reg <= 1'b0;
        end else begin
            wpulse_reg <= do_write;
        end
    end

    // Reset clears every location, so a read after reset returns zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `HP_NUM_REGS; i++) begin
                regs[i] <= `HP_REG_RESET;
            end
        end else if (do_write) begin
            regs[cur_addr] <= bus.data_host_out;
        end
    end
endmodule

// ==== src/host_port_host.sv ====
// Host end: microprocessor bus cycle sequencer for both bus styles
`timescale 1ns/1ps
module host_port_host (
    host_port_if.host               bus,
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               cfg_host_mode,
    input  host_port_pkg::bus_style_t cfg_bus_style,
    input  wire logic               req_valid,
    input  wire logic               req_read,
    input  host_port_pkg::addr_t    req_addr,
    input  host_port_pkg::data_t    req_wdata,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output host_port_pkg::data_t    rsp_rdata
);
    import host_port_pkg::*;

    host_state_t state_reg;
    host_state_t state_next;
    logic        read_reg;
    addr_t       addr_reg;
    data_t       wdata_reg;
    data_t       rdata_reg;
    logic        rsp_reg;

    wire   acked    = !bus.cycle_done_ack_n;
    wire   combined = cfg_bus_style == BUS_COMBINED;
    // Select held through the end phase so the device sees the write strobe rise
    wire   in_cyc   = state_reg != H_IDLE;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            H_IDLE:   if (req_valid && cfg_host_mode) state_next = H_ADDR;
            H_ADDR:   state_next = H_STROBE;
            // RULE15 extend until ack
            H_STROBE: if (acked) state_next = H_END;
            H_END:    state_next = H_IDLE;
        endcase
    end

    assign req_ready = state_reg == H_IDLE && cfg_host_mode;
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;
    assign bus.host_mode = cfg_host_mode;
    assign bus.bus_style = cfg_bus_style;
    assign bus.addr      = addr_reg;
    // RULE10 select during cycle
    assign bus.chip_select_n = !in_cyc;
    // RULE3 split latch pulse; RULE7 RULE8 combined strobe low
    assign bus.addr_latch_or_strobe = combined ? !in_cyc : state_reg == H_ADDR;
    // RULE1 data strobe or read strobe
    assign bus.read_or_data_strobe_n = !(state_reg == H_STROBE && (combined || read_reg));
    // RULE13 direction level; RULE12 write strobe
    assign bus.write_or_rw_id = combined ? read_reg : !(state_reg == H_STROBE && !read_reg);
    assign bus.data_host_out  = wdata_reg;
    assign bus.data_host_oe   = state_reg == H_STROBE && !read_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= H_IDLE;
            read_reg  <= 1'b1;
            addr_reg  <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            rsp_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            rsp_reg   <= state_reg == H_STROBE && acked;
            if (req_valid && req_ready) begin
                read_reg  <= req_read;
                addr_reg  <= req_addr;
                wdata_reg <= req_wdata;
            end
            if (state_reg == H_STROBE && acked && read_reg && bus.data_dev_oe)
                rdata_reg <= bus.data_dev_out;
        end
    end
endmodule

// ==== bench/host_port_asserts.sv ====
// Pin-level checks across the host port
`timescale 1ns/1ps
module host_port_asserts
    import host_port_pkg::*;
(
    input wire logic   clk,
    input wire logic   rst_n,
    input wire logic   host_mode,
    input bus_style_t  bus_style,
    input wire logic   read_or_data_strobe_n,
    input wire logic   addr_latch_or_strobe,
    input wire logic   chip_select_n,
    input wire logic   write_or_rw_id,
    input addr_t       addr,
    input wire logic   data_dev_oe,
    input wire logic   cycle_done_ack_n,
    input wire logic [3:1] send_all_ones,
    input addr_t       last_addr,
    input wire logic   write_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire sel = host_mode && !chip_select_n;
    wire split = bus_style == BUS_SPLIT;
    wire strobe_on = sel && (!read_or_data_strobe_n || (split && !write_or_rw_id));
    chk_idle_bus_quiet: assert property (chip_select_n && $past(chip_select_n) |-> !data_dev_oe)
        else $error("data bus driven while deselected");
    chk_ack_needs_select: assert property (chip_select_n && $past(chip_select_n) |-> cycle_done_ack_n)
        else $error("ack while deselected");
    chk_read_drive_only: assert property (read_or_data_strobe_n && $past(read_or_data_strobe_n) |-> !data_dev_oe)
        else $error("data bus driven without read strobe");
    chk_ack_after_wait: assert property ($fell(cycle_done_ack_n) |-> strobe_on && $past(strobe_on, 2))
        else $error("ack before strobe held two cycles");
    chk_ack_in_time: assert property ($rose(strobe_on) |-> ##[1:4] !cycle_done_ack_n)
        else $error("ack late");
    chk_hw_ones_map: assert property (!host_mode |-> send_all_ones == {chip_select_n, addr_latch_or_strobe,
        read_or_data_strobe_n})
        else $error("hardware mode command mapping wrong");
    chk_host_no_ones: assert property (host_mode |-> send_all_ones == 3'h0)
        else $error("all-ones command in host mode");
    chk_addr_on_fall: assert property (sel && split && $fell(addr_latch_or_strobe) |=> last_addr == $past(addr, 2))
        else $error("address not latched on latch fall");
    chk_split_write: assert property (sel && split && $rose(write_or_rw_id) |-> ##[0:2] write_pulse)
        else $error("split write not committed");
    chk_comb_write: assert property (sel && !split && $rose(read_or_data_strobe_n) && !write_or_rw_id
        |-> ##[0:2] write_pulse)
        else $error("combined write not committed");
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module tb_top;
    import host_port_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cfg_host_mode = 1'b1;
    bus_style_t  cfg_bus_style = BUS_SPLIT;
    logic        req_valid = 1'b0;
    logic        req_read = 1'b0;
    addr_t       req_addr = 7'h00;
    data_t       req_wdata = 8'h00;
    logic        req_ready, rsp_valid, write_pulse;
    data_t       rsp_rdata, last_wdata;
    addr_t       last_addr;
    logic [3:1]  send_all_ones;
    logic [31:0] seed = 32'h00014a81;
    data_t       model [128] = '{default: 8'h00};
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    always #2.5 clk = ~clk;
    host_port_if host_port_if_inst ();
    host_port_device host_port_device_inst (.bus(host_port_if_inst), .clk(clk), .rst_n(rst_n),
        .send_all_ones(send_all_ones), .last_addr(last_addr), .last_wdata(last_wdata), .write_pulse(write_pulse));
    host_port_host host_port_host_inst (.bus(host_port_if_inst), .clk(clk), .rst_n(rst_n),
        .cfg_host_mode(cfg_host_mode), .cfg_bus_style(cfg_bus_style), .req_valid(req_valid), .req_read(req_read),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    host_port_asserts host_port_asserts_inst (.clk(clk), .rst_n(rst_n),
        .host_mode(host_port_if_inst.host_mode), .bus_style(host_port_if_inst.bus_style),
        .read_or_data_strobe_n(host_port_if_inst.read_or_data_strobe_n),
        .addr_latch_or_strobe(host_port_if_inst.addr_latch_or_strobe),
        .chip_select_n(host_port_if_inst.chip_select_n), .write_or_rw_id(host_port_if_inst.write_or_rw_id),
        .addr(host_port_if_inst.addr), .data_dev_oe(host_port_if_inst.data_dev_oe),
        .cycle_done_ack_n(host_port_if_inst.cycle_done_ack_n), .send_all_ones(send_all_ones),
        .last_addr(last_addr), .write_pulse(write_pulse));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [7:0] idle_cmds(input bus_style_t st);
        return (st == BUS_SPLIT) ? 8'h05 : 8'h07;
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic do_op(input logic rd, input addr_t a, input data_t d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_read <= rd;
        req_addr <= a;
        req_wdata <= d;
        n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check("request wait limit", 8'h00, {7'h00, n >= 50});
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        @(negedge clk);
        while (rsp_valid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check("response wait limit", 8'h00, {7'h00, n >= 50});
        if (rd) begin
            check("read data", model[a], rsp_rdata);
        end else begin
            model[a] = d;
            repeat (2) @(negedge clk);
            check("written data", d, last_wdata);
        end
        check("latched address", {1'b0, a}, {1'b0, last_addr});
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            cfg_bus_style <= bus_style_t'(s[0]);
            do_op(1'b1, 7'h7f, 8'h00);
            do_op(1'b0, 7'h7f, 8'hff);
            do_op(1'b0, 7'h00, 8'h00);
            do_op(1'b1, 7'h7f, 8'h00);
            for (int k = 0; k < 60; k++) begin
                seed = xorshift(seed);
                do_op(seed[0], {4'h0, seed[4:2]}, seed[15:8]);
            end
        end
        @(posedge clk);
        rst_n <= 1'b0;
        model = '{default: 8'h00};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        do_op(1'b1, 7'h7f, 8'h00);
        @(posedge clk);
        cfg_host_mode <= 1'b0;
        repeat (8) @(negedge clk);
        check("ready in hardware mode", 8'h00, {7'h00, req_ready});
        check("idle commands combined", idle_cmds(cfg_bus_style), {5'h00, send_all_ones});
        @(posedge clk);
        cfg_bus_style <= BUS_SPLIT;
        @(negedge clk);
        check("idle commands split", idle_cmds(cfg_bus_style), {5'h00, send_all_ones});
        close_out;
    end
endmodule
